// ==== rtl/sadl_delay_line.sv ====
// Stereo serial audio delay line: deserialiser, frame FIFO, delay memory
// and reserialiser. Assumes bclk is slow against core_clk (8x or more).
`timescale 1ns/10ps

// Summary of operation
// - Accept I2S stereo words of any length from 16 to 24 bits.
// - One serial stream in, samples stored, same samples out one stream.
// - Delay setting moves in steps of 256 samples per channel.
// - Memory deep enough for about 170 ms per channel at 48 kHz.
// - Storage counts as empty at reset and after every delay change.
// - Works for bit clock 32 to 64 fs, fs 32 to 192 kHz.
// - All timing taken from incoming bit and word clocks.
// - Delay read from five static select pins, bit zero least significant.
// - Delayed audio driven as serial bits on the one data output.
// - Input bits shifted in on rising bit clock edges.
// - Word clock transitions move finished shift words into sample registers.
// - Word clock low marks left word, high marks right word.
// - Output stream can feed an identical unit so delays add.
// - Delay in samples equals 256 times select plus 255.
// - Both channels always get the same delay.
// - After a delay change, output muted until the full delay passed.

module sadl_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 32
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [PW:0] wr;
        logic [PW:0] rd;
    } sadl_fifo_state_s;

    sadl_fifo_state_s st;
    sadl_fifo_state_s next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             do_wr;
    logic             do_rd;

    // Extra pointer bit tells full from empty
    assign in_ready  = (st.wr[PW-1:0] != st.rd[PW-1:0]) || (st.wr[PW] == st.rd[PW]);
    assign out_valid = (st.wr != st.rd);
    assign out_data  = mem[st.rd[PW-1:0]];
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (do_wr) begin
            next_st.wr = st.wr + 1'b1;
        end
        if (do_rd) begin
            next_st.rd = st.rd + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge core_clk) begin
        if (do_wr) begin
            mem[st.wr[PW-1:0]] <= in_data;
        end
    end

endmodule : sadl_fifo

module sadl_delay_line
    import sadl_pkg::*;
#(
    parameter int ADDR_BITS  = ADDR_W,
    parameter int FIFO_WORDS = FIFO_DEPTH
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             bclk,
    input  wire logic             lrclk,
    input  wire logic             data_in,
    input  wire logic [SEL_W-1:0] delay_select,
    output logic                  data_out
);

    function automatic logic [SAMPLE_W-1:0] place_bit(
        input logic [SAMPLE_W-1:0] word,
        input logic [4:0]          cnt,
        input logic                bit_in
    );
        logic [SAMPLE_W-1:0] res;
        res = word;
        if (cnt < WORD_BITS_MAX) begin
            res[5'(SAMPLE_W - 1) - cnt] = bit_in;
        end
        return res;
    endfunction : place_bit

    sadl_state_s         st;
    sadl_state_s         next_st;
    sadl_frame_s         dly_mem [2**ADDR_W];
    sadl_frame_s         rd_q;
    sadl_frame_s         fifo_data;
    logic                fifo_in_ready;
    logic                fifo_valid;
    logic                pop;
    logic [ADDR_W-1:0]   delay;
    logic [ADDR_W-1:0]   rd_addr;
    logic                rise;
    logic                fall;
    logic                lr_chg;
    logic [SAMPLE_W-1:0] word;

    sadl_fifo #(
        .WIDTH ($bits(sadl_frame_s)),
        .DEPTH (FIFO_WORDS)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (st.push),
        .in_ready  (fifo_in_ready),
        .in_data   (st.push_frame),
        .out_valid (fifo_valid),
        .out_ready (!st.rd_busy && !st.out_full),
        .out_data  (fifo_data)
    );

    // Edges found by core_clk sampling; pins never clock anything
    assign rise   = st.sync2.bclk && !st.bclk_d;
    assign fall   = !st.sync2.bclk && st.bclk_d;
    assign lr_chg = rise && (st.sync2.lr != st.lr_prev);
    assign word   = place_bit(st.in_shift, st.in_cnt, st.sync2.data);

    assign delay   = {st.sel, DELAY_BASE_BITS};
    assign rd_addr = st.wr_ptr - delay;
    assign pop     = fifo_valid && !st.rd_busy && !st.out_full;
    assign data_out = st.data_out;

    always_comb begin
        next_st = st;
        next_st.sync1 = '{sel: delay_select, data: data_in, lr: lrclk, bclk: bclk};
        next_st.sync2 = st.sync1;
        next_st.bclk_d = st.sync2.bclk;

        // Held until the FIFO takes it, so a full FIFO stalls this stage
        if (st.push && fifo_in_ready) begin
            next_st.push = 1'b0;
        end

        if (rise) begin
            next_st.lr_prev = st.sync2.lr;
            if (lr_chg) begin
                // Bit on this edge is the old word's LSB
                next_st.in_shift = '0;
                next_st.in_cnt   = '0;
                if (!st.lr_prev) begin
                    next_st.left_hold = word;
                end else begin
                    next_st.push       = 1'b1;
                    next_st.push_frame = '{left: st.left_hold, right: word};
                end
            end else begin
                next_st.in_shift = word;
                if (st.in_cnt < WORD_BITS_MAX) begin
                    next_st.in_cnt = st.in_cnt + 5'h01;
                end
            end
        end

        // A changed select restarts the fill count, so memory reads as empty
        if (st.sync2.sel != st.sel) begin
            next_st.sel  = st.sync2.sel;
            next_st.fill = ADDR_ZERO;
        end else if (pop && st.fill < delay) begin
            next_st.fill = st.fill + ADDR_ONE;
        end

        // One address per frame keeps both channels aligned
        if (pop) begin
            next_st.wr_ptr   = st.wr_ptr + ADDR_ONE;
            next_st.rd_busy  = 1'b1;
            next_st.muted_rd = (st.fill < delay) || (st.sync2.sel != st.sel);
        end
        if (st.rd_busy) begin
            next_st.rd_busy  = 1'b0;
            next_st.out_full = 1'b1;
            next_st.out_pair = st.muted_rd ? '0 : rd_q;
        end

        // Next word loaded on the same edge the input sees the change
        if (lr_chg) begin
            if (!st.sync2.lr) begin
                next_st.out_shift = st.out_full ? st.out_pair.left : '0;
                next_st.cur_right = st.out_full ? st.out_pair.right : '0;
                // A frame landing now is kept for the next boundary
                next_st.out_full  = st.rd_busy;
            end else begin
                next_st.out_shift = st.cur_right;
            end
        end else if (fall) begin
            // MSB first on the first fall; words cut at short frames
            next_st.data_out  = st.out_shift[SAMPLE_W-1];
            next_st.out_shift = {st.out_shift[SAMPLE_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Memory is never cleared; the fill count hides stale contents instead
    always_ff @(posedge core_clk) begin
        if (pop) begin
            dly_mem[st.wr_ptr] <= fifo_data;
            rd_q               <= dly_mem[rd_addr];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Properties watch the synced copies only; raw pins are never sampled here

    AST_DELAY_STEP: assert property (
        pop |=> st.wr_ptr == ADDR_ONE + $past(rd_addr) + $past(delay))
        else $error("read address not delay frames behind write");

    AST_MUTE_ZERO: assert property (
        st.rd_busy && st.muted_rd |=> st.out_full && st.out_pair == '0)
        else $error("muted frame not zero");

    AST_SEL_CLEARS: assert property (
        st.sync2.sel != st.sel |=> st.fill == ADDR_ZERO && st.sel == $past(st.sync2.sel))
        else $error("select change did not restart fill");

    AST_FILL_BOUND: assert property (
        st.sel == $past(st.sel) |-> st.fill <= delay)
        else $error("fill count beyond delay");

    AST_UNMUTE: assert property (
        pop && st.fill == delay && st.sync2.sel == st.sel ##1 st.rd_busy |-> !st.muted_rd)
        else $error("full delay passed but still muted");

    AST_SHIFT_RISE: assert property (
        rise && !lr_chg && st.in_cnt < WORD_BITS_MAX |=> st.in_cnt == $past(st.in_cnt) + 5'h01)
        else $error("bit not shifted on rising edge");

    AST_RIGHT_PUSH: assert property (
        lr_chg && st.lr_prev |=> st.push && st.push_frame.right == $past(word))
        else $error("right word not pushed at word clock change");

    AST_LEFT_HOLD: assert property (
        lr_chg && !st.lr_prev |=> st.left_hold == $past(word) && st.in_cnt == 5'h00)
        else $error("left word not held at word clock change");

    AST_OUT_FALL: assert property (
        fall && !lr_chg |=> st.data_out == $past(st.out_shift[SAMPLE_W-1]))
        else $error("output bit not taken on falling edge");

    AST_PUSH_HELD: assert property (
        st.push && !fifo_in_ready |=> st.push && $stable(st.push_frame))
        else $error("frame lost under back-pressure");

    AST_LOAD_LEFT: assert property (
        lr_chg && !st.sync2.lr && st.out_full |=> st.out_shift == $past(st.out_pair.left))
        else $error("left word not loaded at word clock change");

    AST_CUR_RIGHT: assert property (
        lr_chg && !st.sync2.lr && st.out_full |=> st.cur_right == $past(st.out_pair.right))
        else $error("right word not kept with its left word");

    AST_LOAD_RIGHT: assert property (
        lr_chg && st.sync2.lr |=> st.out_shift == $past(st.cur_right))
        else $error("right word not loaded at word clock change");

    AST_UNDERRUN: assert property (
        lr_chg && !st.sync2.lr && !st.out_full |=> st.out_shift == '0 && st.cur_right == '0)
        else $error("underrun did not send silence");

    AST_OUT_FULL_SET: assert property (
        st.rd_busy |=> st.out_full)
        else $error("read frame not kept for output");

    AST_LR_TRACK: assert property (
        rise |=> st.lr_prev == $past(st.sync2.lr))
        else $error("word clock level not tracked on rising edge");

    AST_PUSH_LEFT: assert property (
        lr_chg && st.lr_prev |=> st.push_frame.left == $past(st.left_hold))
        else $error("held left word not pushed with right word");

    AST_PUSH_ONCE: assert property (
        st.push && fifo_in_ready && !(lr_chg && st.lr_prev) |=> !st.push)
        else $error("frame pushed twice");

    AST_OUT_HOLD: assert property (
        !fall |=> st.data_out == $past(st.data_out))
        else $error("output bit changed without a falling edge");

    AST_DELAY_VALUE: assert property (
        int'(delay) == DELAY_STEP * int'(st.sel) + DELAY_BASE)
        else $error("delay not step times select plus base");

    AST_ONE_POP: assert property (
        pop |=> !pop)
        else $error("more than one memory address per frame");

    AST_SYNC_EDGE: assert property (
        rise |-> $past(st.sync1.bclk) && !$past(st.sync2.bclk))
        else $error("bit clock edge not taken through the synchroniser");

    AST_MSB_FIRST: assert property (
        lr_chg |=> st.in_cnt == 5'h00 && st.in_shift == '0)
        else $error("new word does not start at its first bit");

    AST_FILL_STEP: assert property (
        pop && st.fill < delay && st.sync2.sel == st.sel |=> st.fill == $past(st.fill) + ADDR_ONE)
        else $error("fill count did not advance on a frame");

    AST_MUTE_FLAG: assert property (
        pop && st.fill < delay |=> st.muted_rd)
        else $error("frame read before full delay not muted");

    COV_PUSH:    cover property (st.push && fifo_in_ready);
    COV_UNMUTE:  cover property (st.rd_busy && $fell(st.muted_rd));
    COV_SEL_CHG: cover property (st.sync2.sel != st.sel ##1 st.fill == ADDR_ZERO);
    COV_STALL:   cover property (st.push && !fifo_in_ready);
    COV_LOAD:    cover property (lr_chg && !st.sync2.lr && st.out_full);

endmodule : sadl_delay_line

// ==== rtl/sadl_pkg.sv ====
// Constants and carrier types for the stereo audio serial delay line.
// Assumes a single core clock; all audio pins are asynchronous to it.
package sadl_pkg;

    localparam int SAMPLE_W   = 24;
    localparam int SEL_W      = 5;
    localparam int ADDR_W     = 13;
    localparam int FIFO_DEPTH = 32;
    localparam int PIN_W      = 8;

    // Delay in frames is step * select + base; base fills the low byte
    localparam int DELAY_STEP = 256;
    localparam int DELAY_BASE = 255;
    localparam logic [7:0] DELAY_BASE_BITS = 8'hFF;

    // Bits kept per word; longer words are cut, shorter ones zero padded
    localparam logic [4:0] WORD_BITS_MAX = 5'h18;

    localparam logic [PIN_W-1:0] PIN_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 13'h0000;
    localparam logic [ADDR_W-1:0] ADDR_ONE  = 13'h0001;

    // Core clock period, and the link bit clock the bench drives, both in ns
    localparam int CORE_PERIOD_NS = 8;
    localparam int LINK_PERIOD_NS = 125;

    typedef struct packed {
        logic [SAMPLE_W-1:0] left;
        logic [SAMPLE_W-1:0] right;
    } sadl_frame_s;

    // Pin bundle: {select, serial data, word clock, bit clock}
    typedef struct packed {
        logic [SEL_W-1:0] sel;
        logic             data;
        logic             lr;
        logic             bclk;
    } sadl_pins_s;

    typedef struct packed {
        sadl_pins_s          sync1;
        sadl_pins_s          sync2;
        logic                bclk_d;
        logic                lr_prev;
        logic [SAMPLE_W-1:0] in_shift;
        logic [4:0]          in_cnt;
        logic [SAMPLE_W-1:0] left_hold;
        logic                push;
        sadl_frame_s         push_frame;
        logic [SEL_W-1:0]    sel;
        logic [ADDR_W-1:0]   wr_ptr;
        logic [ADDR_W-1:0]   fill;
        logic                rd_busy;
        logic                muted_rd;
        logic                out_full;
        sadl_frame_s         out_pair;
        logic [SAMPLE_W-1:0] cur_right;
        logic [SAMPLE_W-1:0] out_shift;
        logic                data_out;
    } sadl_state_s;

endpackage : sadl_pkg

// ==== testbench/sadl_src_model.sv ====
// Audio source model: drives an I2S stream of 16-bit words, 32 bit clocks
// per frame, and captures the delayed stream that comes back.
// Assumes the bench calls send_frame back to back while the stream runs.
`timescale 1ns/10ps
module sadl_src_model
    import sadl_pkg::*;
(
    output logic      bclk,
    output logic      lrclk,
    output logic      data_in,
    input  wire logic data_out
);
    localparam real HALF_NS = LINK_PERIOD_NS / 2.0;
    int          tx_count;
    logic [15:0] rx_word;
    logic [15:0] rx_left;
    logic        rx_lr;
    logic        last_bit;
    logic [31:0] rx_q[$];
    int          rx_at[$];

    initial begin
        bclk = 1'b0;
        lrclk = 1'b1;
        data_in = 1'b0;
        last_bit = 1'b0;
        tx_count = 0;
        rx_word = 16'h0000;
        rx_left = 16'h0000;
        rx_lr = 1'b1;
    end

    // Bit clock only runs inside frames; it stands high between calls
    task automatic send_frame(input logic [15:0] left, input logic [15:0] right);
        logic [31:0] bits;
        bits = {left, right};
        for (int i = 0; i < 32; i++) begin
            bclk = 1'b0;
            lrclk = (i >= 16);
            data_in = (i == 0) ? last_bit : bits[32-i];
            #(HALF_NS);
            bclk = 1'b1;
            #(HALF_NS);
        end
        last_bit = bits[0];
        tx_count++;
    endtask : send_frame

    // Slot after a word clock change carries the previous word's LSB
    always @(posedge bclk) begin
        if (lrclk != rx_lr) begin
            if (!rx_lr) begin
                rx_left = {rx_word[14:0], data_out};
            end else begin
                rx_q.push_back({rx_left, rx_word[14:0], data_out});
                rx_at.push_back(tx_count);
            end
            rx_word = 16'h0000;
        end else begin
            rx_word = {rx_word[14:0], data_out};
        end
        rx_lr = lrclk;
    end
endmodule : sadl_src_model

// ==== testbench/stereo_audio_serial_delay_line_tb.sv ====
// Testbench for the delay line: random stereo stream, select glitch,
// mute length and delay checked against a queue model of the delay.
// Assumes the source model in its own file and a 125 ns bit clock.
`timescale 1ns/10ps
module stereo_audio_serial_delay_line_tb;
    import sadl_pkg::*;
    localparam int NFRAMES = 272;
    localparam int CHG_AT  = 4;
    localparam int LIMIT   = 150000;
    localparam int DLY     = DELAY_STEP * 0 + DELAY_BASE;
    // One frame of output pipeline plus two of framing at the model
    localparam int PIPE    = 3;

    logic             core_clk;
    logic             rst;
    logic [SEL_W-1:0] delay_select;
    logic             bclk;
    logic             lrclk;
    logic             data_in;
    logic             data_out;
    int               failures;
    int               checks;
    int               cycles;
    logic [31:0]      sent[$];

    sadl_delay_line sadl_delay_line_inst (
        .core_clk     (core_clk),
        .rst          (rst),
        .bclk         (bclk),
        .lrclk        (lrclk),
        .data_in      (data_in),
        .delay_select (delay_select),
        .data_out     (data_out)
    );

    sadl_src_model sadl_src_model_inst (
        .bclk     (bclk),
        .lrclk    (lrclk),
        .data_in  (data_in),
        .data_out (data_out)
    );

    initial begin
        core_clk = 1'b0;
        forever #(CORE_PERIOD_NS / 2.0) core_clk = ~core_clk;
    end

    task automatic report(input string msg);
        failures++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask : report

    task automatic conclude();
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            report("run did not finish");
            conclude();
        end
    end

    initial begin
        int          first;
        int          src;
        int          lag;
        int          k;
        int          at;
        logic [31:0] w;
        rst = 1'b1;
        delay_select = 5'h00;
        failures = 0;
        checks = 0;
        cycles = 0;
        void'($urandom(32'hD332));
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        for (int f = 0; f < NFRAMES; f++) begin
            // Short select glitch: mute must restart from the last change
            if (f == 2 || f == CHG_AT) begin
                @(posedge core_clk);
                delay_select <= (f == 2) ? 5'h01 : 5'h00;
            end
            w = $urandom | 32'h0001_0001;
            sent.push_back(w);
            sadl_src_model_inst.send_frame(w[31:16], w[15:0]);
        end
        first = -1;
        foreach (sadl_src_model_inst.rx_q[i]) begin
            if (first < 0 && sadl_src_model_inst.rx_q[i] !== 32'h0000_0000) first = i;
        end
        checks++;
        if (first < 0) report("no delayed audio seen");
        if (first >= 0) begin
            src = -1;
            foreach (sent[j]) begin
                if (src < 0 && sent[j] === sadl_src_model_inst.rx_q[first]) src = j;
            end
            lag = sadl_src_model_inst.rx_at[first] - src;
            checks++;
            if (src < 0 || lag != DLY + PIPE) report("delay length off");
            at = sadl_src_model_inst.rx_at[first];
            checks++;
            if (at < CHG_AT + DLY) report("mute too short");
            for (int i = first + 1; i < sadl_src_model_inst.rx_q.size(); i++) begin
                k = sadl_src_model_inst.rx_at[i] - DLY - PIPE;
                w = sadl_src_model_inst.rx_q[i];
                checks++;
                if (k < 0 || k >= sent.size() || w !== sent[k]) begin
                    report("delayed frame differs");
                end
            end
        end
        conclude();
    end
endmodule : stereo_audio_serial_delay_line_tb
